// *** bench/boot_link_assertions.sv ***
// concurrent checks on the byte link between controller and device
`timescale 1ns/1ns
module boot_link_assertions (
    // clock and reset
    input wire logic       clk_sys,
    input wire logic       rst_b,
    // link
    input wire logic       h2dValid,
    input wire logic [7:0] h2dData,
    input wire logic       h2dFrameErr,
    input wire logic       h2dOverrun,
    input wire logic       d2hValid,
    input wire logic [7:0] d2hData
);
    logic [3:0] nBytes;
    logic       secFirst;
    logic       emuFirst;
    logic       hGood;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    assign hGood = h2dValid && !h2dFrameErr && !h2dOverrun;
    // byte count since reset tells which slot of the first command is running
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            nBytes   <= 4'h0;
            secFirst <= 1'b0;
            emuFirst <= 1'b0;
        end
        else if (h2dValid)
        begin
            nBytes <= (nBytes == 4'hF) ? nBytes : nBytes + 4'h1;
            if (nBytes == 4'h2)
            begin
                secFirst <= hGood && (h2dData == boot_cmd_pkg::CMD_SECURITY);
                emuFirst <= hGood && (h2dData == boot_cmd_pkg::CMD_EMULATION);
            end
        end
    end
    property p_sync1_echo;
        nBytes == 4'h0 && hGood && (h2dData == 8'h86 || h2dData == 8'h30)
        |=> d2hValid && d2hData == $past(h2dData);
    endproperty
    a_sync1_echo: assert property (p_sync1_echo) else $error("sync1 echo wrong");
    property p_sync2_echo;
        nBytes == 4'h1 && hGood && (h2dData == 8'h79 || h2dData == 8'hCF)
        |=> d2hValid && d2hData == $past(h2dData);
    endproperty
    a_sync2_echo: assert property (p_sync2_echo) else $error("sync2 echo wrong");
    property p_cmd_echo;
        nBytes == 4'h2 && hGood && (h2dData == 8'hFA || h2dData == 8'hD0)
        |=> d2hValid && d2hData == $past(h2dData);
    endproperty
    a_cmd_echo: assert property (p_cmd_echo) else $error("command echo wrong");
    property p_frame_code;
        h2dValid && h2dFrameErr |=> d2hValid && d2hData == boot_cmd_pkg::ERR_FRAMING;
    endproperty
    a_frame_code: assert property (p_frame_code) else $error("framing code wrong");
    property p_overrun_code;
        h2dValid && h2dOverrun && !h2dFrameErr
        |=> d2hValid && d2hData == boot_cmd_pkg::ERR_OVERRUN;
    endproperty
    a_overrun_code: assert property (p_overrun_code) else $error("overrun code wrong");
    // three copies, then the link must stay quiet for 8 cycles
    property p_err_triple;
        d2hValid && !$past(d2hValid) && (d2hData == 8'hA1 || d2hData == 8'hA3 ||
        d2hData == 8'h63) |=> (d2hValid && d2hData == $past(d2hData))[*2]
        ##1 !d2hValid[*8];
    endproperty
    a_err_triple: assert property (p_err_triple) else $error("error triple wrong");
    property p_addr_silent;
        secFirst && h2dValid && nBytes >= 4'h3 && nBytes <= 4'h8 |=> !d2hValid[*8];
    endproperty
    a_addr_silent: assert property (p_addr_silent) else $error("address reply");
    property p_value_ack;
        emuFirst && nBytes == 4'h3 && hGood
        |=> d2hValid && d2hData == boot_cmd_pkg::ACK_EMULATION;
    endproperty
    a_value_ack: assert property (p_value_ack) else $error("set value ack wrong");
    c_emu: cover property (d2hValid && d2hData == boot_cmd_pkg::ACK_EMULATION);
    c_sec: cover property (d2hValid && d2hData == boot_cmd_pkg::ACK_SECURITY);
    c_err: cover property (d2hValid && d2hData == boot_cmd_pkg::ERR_FRAMING);
endmodule

// *** bench/test_serial_boot_security_cmds.sv ***
// bench joining controller and device ends over the byte link
`timescale 1ns/1ns
module test_serial_boot_security_cmds;
    logic clk_sys = 1'b0, rst_b = 1'b0, blank = 1'b0, start = 1'b0, opSecurity = 1'b0;
    logic injectFrameErr = 1'b0, injectOverrun = 1'b0, pwBad = 1'b0;
    logic securityEnabled, stopped, busy, done, ok, needReset;
    logic [23:0] memAddr, countAddr = 24'h000010, compareAddr = 24'h000020;
    logic [7:0] memData, pwIdx, pwData, reply, setValue = 8'h55, pwLen = 8'h04;
    logic [7:0] mem [0:255];
    int err_count = 0, checks_done = 0;
    always #5 clk_sys = ~clk_sys;
    // one-cycle flash latency, as the device expects
    always_ff @(posedge clk_sys) memData <= mem[memAddr[7:0]];
    assign pwData = mem[8'(8'h20 + pwIdx)] ^ {7'h0, pwBad};
    boot_link_if link ();
    boot_cmd_device boot_cmd_device_i (.clk_sys, .rst_b, .link(link), .blank, .memAddr,
        .memData, .securityEnabled, .stopped);
    boot_cmd_host boot_cmd_host_i (.clk_sys, .rst_b, .link(link), .start, .opSecurity,
        .setValue, .countAddr, .compareAddr, .pwLen, .injectFrameErr, .injectOverrun,
        .pwIdx, .pwData, .busy, .done, .ok, .needReset, .reply);
    boot_link_assertions boot_link_assertions_i (.clk_sys, .rst_b,
        .h2dValid(link.h2dValid), .h2dData(link.h2dData), .h2dFrameErr(link.h2dFrameErr),
        .h2dOverrun(link.h2dOverrun), .d2hValid(link.d2hValid), .d2hData(link.d2hData));
    task automatic end_of_test();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic do_reset();
        rst_b = 1'b0;
        repeat (3) @(negedge clk_sys);
        rst_b = 1'b1;
    endtask
    // bounded wait: a silent hang counts as a mismatch
    task automatic run_cmd(input logic sec, input logic fe, input logic ov);
        int n;
        @(negedge clk_sys);
        opSecurity = sec;
        injectFrameErr = fe;
        injectOverrun = ov;
        start = 1'b1;
        @(negedge clk_sys);
        start = 1'b0;
        check8("busy", 8'h01, {7'h0, busy});
        n = 0;
        while (done !== 1'b1 && n < 3000)
        begin
            @(negedge clk_sys);
            n++;
        end
        if (n >= 3000)
        begin
            check8("done", 8'h01, 8'h00);
            end_of_test();
        end
    endtask
    task automatic t_emu_then_sec();
        do_reset();
        run_cmd(1'b0, 1'b0, 1'b0);
        check8("emu reply", boot_cmd_pkg::ACK_EMULATION, reply);
        check8("emu ok", 8'h01, {7'h0, ok});
        check8("emu no effect", 8'h00, {7'h0, securityEnabled});
        check8("emu idle", 8'h00, {7'h0, busy});
        run_cmd(1'b1, 1'b0, 1'b0);
        check8("sec reply", boot_cmd_pkg::ACK_SECURITY, reply);
        check8("sec ok", 8'h01, {7'h0, ok});
        check8("sec on", 8'h01, {7'h0, securityEnabled});
    endtask
    task automatic t_link_err(input logic fe, input logic ov, input logic [7:0] code);
        do_reset();
        run_cmd(1'b0, fe, ov);
        repeat (12) @(negedge clk_sys);
        check8("err reply", code, reply);
        check8("err stopped", 8'h01, {7'h0, stopped});
        check8("err needReset", 8'h01, {7'h0, needReset});
    endtask
    task automatic t_sec_fail(input logic isBlank, input logic wrongPw);
        do_reset();
        blank = isBlank;
        pwBad = wrongPw;
        run_cmd(1'b1, 1'b0, 1'b0);
        repeat (12) @(negedge clk_sys);
        check8("fail reply", boot_cmd_pkg::CMD_SECURITY, reply);
        check8("fail ok", 8'h00, {7'h0, ok});
        check8("fail stopped", 8'h01, {7'h0, stopped});
        check8("fail sec", 8'h00, {7'h0, securityEnabled});
        blank = 1'b0;
        pwBad = 1'b0;
    endtask
    initial
    begin
        for (int i = 0; i < 256; i++)
            mem[i] = 8'h00;
        mem[8'h10] = 8'h04;
        for (int i = 0; i < 4; i++)
            mem[8'h20 + i] = 8'(8'h11 * (i + 1));
        t_emu_then_sec();
        t_link_err(1'b1, 1'b0, boot_cmd_pkg::ERR_FRAMING);
        t_link_err(1'b0, 1'b1, boot_cmd_pkg::ERR_OVERRUN);
        t_link_err(1'b1, 1'b1, boot_cmd_pkg::ERR_FRAMING);
        t_sec_fail(1'b0, 1'b1);
        t_sec_fail(1'b1, 1'b0);
        end_of_test();
    end
endmodule

// *** pkg/boot_cmd_pkg.sv ***
// shared constants and types for the serial boot command link
package boot_cmd_pkg;
    localparam logic [7:0] SYNC1_A        = 8'h86;
    localparam logic [7:0] SYNC1_B        = 8'h30;
    localparam logic [7:0] SYNC2_A        = 8'h79;
    localparam logic [7:0] SYNC2_B        = 8'hCF;
    localparam logic [7:0] CMD_SECURITY   = 8'hFA;
    localparam logic [7:0] CMD_EMULATION  = 8'hD0;
    localparam logic [7:0] ACK_EMULATION  = 8'hD1;
    localparam logic [7:0] ACK_SECURITY   = 8'hFB;
    localparam logic [7:0] ERR_FRAMING    = 8'hA1;
    localparam logic [7:0] ERR_OVERRUN    = 8'hA3;
    localparam logic [7:0] ERR_COMMAND    = 8'h63;
    localparam logic [1:0] ERR_REPEAT     = 2'h3;
    localparam logic [1:0] ADDR_BYTES     = 2'h3;
    localparam int         EMU_MIN_KB     = 96;
    localparam int         DEV_FLASH_KB   = 64;
    localparam logic       EMU_ACTIVE     = (DEV_FLASH_KB > EMU_MIN_KB);
    localparam int         CLK_PERIOD_NS  = 10;
    localparam int         SLOT_NS        = 80;
    localparam logic [7:0] SLOT_CYC       = 8'((SLOT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [8:0] STEP_SYNC1     = 9'h000;
    localparam logic [8:0] STEP_SYNC2     = 9'h001;
    localparam logic [8:0] STEP_CMD       = 9'h002;
    localparam logic [8:0] STEP_FIRST_OP  = 9'h003;
    localparam logic [8:0] STEP_LAST_ADDR = 9'h008;
    localparam logic [8:0] STEP_PW        = 9'h009;

    typedef enum logic [3:0] {
        D_SYNC1, D_SYNC2, D_CMD, D_EMUVAL, D_CNTADDR, D_CMPADDR,
        D_CNTFETCH, D_CNTLATCH, D_PWSTR, D_ERR, D_IDLE
    } dev_state_t;

    typedef enum logic [2:0] {
        H_READY, H_SEND, H_WAIT, H_DEAD
    } host_state_t;
endpackage

// *** pkg/boot_link_if.sv ***
// byte-level serial link between the programming controller and the device
`timescale 1ns/1ns
interface boot_link_if;
    logic       h2dValid;
    logic [7:0] h2dData;
    logic       h2dFrameErr;
    logic       h2dOverrun;
    logic       d2hValid;
    logic [7:0] d2hData;

    modport device (
        input  h2dValid,
        input  h2dData,
        input  h2dFrameErr,
        input  h2dOverrun,
        output d2hValid,
        output d2hData
    );

    modport host (
        output h2dValid,
        output h2dData,
        output h2dFrameErr,
        output h2dOverrun,
        input  d2hValid,
        input  d2hData
    );
endinterface

// *** verilog/boot_cmd_device.sv ***
// device end: boot mode command interpreter for sync, emulation and security commands
`timescale 1ns/1ns

module boot_cmd_device (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    // serial link
    boot_link_if.device      link,
    // flash side
    input  wire logic        blank,
    output logic      [23:0] memAddr,
    input  wire logic [7:0]  memData,
    // status
    output logic             securityEnabled,
    output logic             stopped
);
    typedef struct packed {
        boot_cmd_pkg::dev_state_t state;
        logic                     txValid;
        logic [7:0]               txData;
        logic [1:0]               errCnt;
        logic [1:0]               byteIdx;
        logic [23:0]              cntAddr;
        logic [23:0]              cmpAddr;
        logic [23:0]              memAddr;
        logic [7:0]               pwCnt;
        logic [7:0]               pwIdx;
        logic                     pwBad;
        logic                     secOn;
        logic                     stopped;
    } dev_st_t;

    dev_st_t st;
    dev_st_t next_st;
    logic    rxOk;
    logic    rxErr;

    assign link.d2hValid   = st.txValid;
    assign link.d2hData    = st.txData;
    assign memAddr         = st.memAddr;
    assign securityEnabled = st.secOn;
    assign stopped         = st.stopped;

    always_comb
    begin
        next_st         = st;
        next_st.txValid = 1'b0;
        rxErr           = link.h2dFrameErr | link.h2dOverrun;
        rxOk            = link.h2dValid & ~rxErr;
        case (st.state)
            boot_cmd_pkg::D_SYNC1:
            begin
                // baud is taken from this byte by the link layer; only its value and its error flags are judged
                if (rxOk && (link.h2dData == boot_cmd_pkg::SYNC1_A ||
                             link.h2dData == boot_cmd_pkg::SYNC1_B))
                begin
                    next_st.txValid = 1'b1;
                    next_st.txData  = link.h2dData;
                    next_st.state   = boot_cmd_pkg::D_SYNC2;
                end
            end
            boot_cmd_pkg::D_SYNC2:
            begin
                if (link.h2dValid)
                begin
                    if (rxOk && (link.h2dData == boot_cmd_pkg::SYNC2_A ||
                                 link.h2dData == boot_cmd_pkg::SYNC2_B))
                    begin
                        next_st.txValid = 1'b1;
                        next_st.txData  = link.h2dData;
                        next_st.state   = boot_cmd_pkg::D_CMD;
                    end
                    else
                    begin
                        next_st.state = boot_cmd_pkg::D_SYNC1;
                    end
                end
            end
            boot_cmd_pkg::D_CMD:
            begin
                if (link.h2dValid)
                begin
                    next_st.txValid = 1'b1;
                    next_st.errCnt  = 2'h1;
                    next_st.state   = boot_cmd_pkg::D_ERR;
                    if (link.h2dFrameErr)
                    begin
                        next_st.txData = boot_cmd_pkg::ERR_FRAMING;
                    end
                    else if (link.h2dOverrun)
                    begin
                        next_st.txData = boot_cmd_pkg::ERR_OVERRUN;
                    end
                    else if (link.h2dData == boot_cmd_pkg::CMD_EMULATION)
                    begin
                        next_st.txData = link.h2dData;
                        next_st.state  = boot_cmd_pkg::D_EMUVAL;
                    end
                    else if (link.h2dData == boot_cmd_pkg::CMD_SECURITY)
                    begin
                        next_st.txData  = link.h2dData;
                        next_st.byteIdx = 2'h0;
                        // a blank part has nothing to protect: echo, then fall silent
                        next_st.state   = blank ? boot_cmd_pkg::D_IDLE
                                                : boot_cmd_pkg::D_CNTADDR;
                    end
                    else
                    begin
                        next_st.txData = boot_cmd_pkg::ERR_COMMAND;
                    end
                end
            end
            boot_cmd_pkg::D_ERR:
            begin
                next_st.txValid = 1'b1;
                next_st.errCnt  = st.errCnt + 2'h1;
                if (st.errCnt == boot_cmd_pkg::ERR_REPEAT - 2'h1)
                begin
                    next_st.state = boot_cmd_pkg::D_IDLE;
                end
            end
            boot_cmd_pkg::D_EMUVAL:
            begin
                // value is taken and dropped; EMU_ACTIVE is false for this flash size
                if (rxOk)
                begin
                    next_st.txValid = 1'b1;
                    next_st.txData  = boot_cmd_pkg::ACK_EMULATION;
                    next_st.state   = boot_cmd_pkg::D_CMD;
                end
                else if (link.h2dValid)
                begin
                    next_st.state = boot_cmd_pkg::D_IDLE;
                end
            end
            boot_cmd_pkg::D_CNTADDR, boot_cmd_pkg::D_CMPADDR:
            begin
                if (link.h2dValid && rxErr)
                begin
                    next_st.state = boot_cmd_pkg::D_IDLE;
                end
                else if (rxOk)
                begin
                    next_st.byteIdx = st.byteIdx + 2'h1;
                    if (st.state == boot_cmd_pkg::D_CNTADDR)
                    begin
                        next_st.cntAddr = {st.cntAddr[15:0], link.h2dData};
                    end
                    else
                    begin
                        next_st.cmpAddr = {st.cmpAddr[15:0], link.h2dData};
                    end
                    if (st.byteIdx == boot_cmd_pkg::ADDR_BYTES - 2'h1)
                    begin
                        next_st.byteIdx = 2'h0;
                        if (st.state == boot_cmd_pkg::D_CNTADDR)
                        begin
                            next_st.state = boot_cmd_pkg::D_CMPADDR;
                        end
                        else
                        begin
                            next_st.memAddr = st.cntAddr;
                            next_st.state   = boot_cmd_pkg::D_CNTFETCH;
                        end
                    end
                end
            end
            boot_cmd_pkg::D_CNTFETCH:
            begin
                next_st.state = boot_cmd_pkg::D_CNTLATCH;
            end
            boot_cmd_pkg::D_CNTLATCH:
            begin
                // a zero count cannot match any string, so it is treated as a mismatch
                next_st.pwCnt   = memData;
                next_st.pwIdx   = 8'h00;
                next_st.pwBad   = 1'b0;
                next_st.memAddr = st.cmpAddr;
                next_st.state   = (memData == 8'h00) ? boot_cmd_pkg::D_IDLE
                                                     : boot_cmd_pkg::D_PWSTR;
            end
            boot_cmd_pkg::D_PWSTR:
            begin
                if (link.h2dValid && rxErr)
                begin
                    next_st.state = boot_cmd_pkg::D_IDLE;
                end
                else if (rxOk)
                begin
                    next_st.pwBad   = st.pwBad | (link.h2dData != memData);
                    next_st.pwIdx   = st.pwIdx + 8'h01;
                    next_st.memAddr = st.memAddr + 24'h000001;
                    if (st.pwIdx == st.pwCnt - 8'h01)
                    begin
                        if (next_st.pwBad)
                        begin
                            next_st.state = boot_cmd_pkg::D_IDLE;
                        end
                        else
                        begin
                            next_st.txValid = 1'b1;
                            next_st.txData  = boot_cmd_pkg::ACK_SECURITY;
                            next_st.secOn   = 1'b1;
                            next_st.state   = boot_cmd_pkg::D_CMD;
                        end
                    end
                end
            end
            boot_cmd_pkg::D_IDLE:
            begin
                // only rst_b leaves this state
                next_st.state = boot_cmd_pkg::D_IDLE;
            end
            default:
            begin
                next_st.state = boot_cmd_pkg::D_IDLE;
            end
        endcase
        next_st.stopped = (next_st.state == boot_cmd_pkg::D_IDLE);
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st       <= '0;
            st.state <= boot_cmd_pkg::D_SYNC1;
        end
        else
        begin
            st <= next_st;
        end
    end
endmodule

// *** verilog/boot_cmd_host.sv ***
// controller end: issues emulation or security commands over the byte link
`timescale 1ns/1ns
module boot_cmd_host (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    // serial link
    boot_link_if.host        link,
    // command request
    input  wire logic        start,
    input  wire logic        opSecurity,
    input  wire logic [7:0]  setValue,
    input  wire logic [23:0] countAddr,
    input  wire logic [23:0] compareAddr,
    input  wire logic [7:0]  pwLen,
    input  wire logic        injectFrameErr,
    input  wire logic        injectOverrun,
    // password source
    output logic      [7:0]  pwIdx,
    input  wire logic [7:0]  pwData,
    // result
    output logic             busy,
    output logic             done,
    output logic             ok,
    output logic             needReset,
    output logic      [7:0]  reply
);
    typedef struct packed {
        boot_cmd_pkg::host_state_t state;
        logic [8:0]                step;
        logic [8:0]                lastStep;
        logic                      op;
        logic                      synced;
        logic [7:0]                timer;
        logic [7:0]                expByte;
        logic                      needReply;
        logic [47:0]               addrSh;
        logic [7:0]                setVal;
        logic                      faultF;
        logic                      faultO;
        logic                      txValid;
        logic [7:0]                txData;
        logic                      txFe;
        logic                      txOv;
        logic [7:0]                pwIdx;
        logic                      busy;
        logic                      done;
        logic                      ok;
        logic                      dead;
        logic [7:0]                reply;
    } host_st_t;

    host_st_t st;
    host_st_t next_st;

    assign link.h2dValid    = st.txValid;
    assign link.h2dData     = st.txData;
    assign link.h2dFrameErr = st.txFe;
    assign link.h2dOverrun  = st.txOv;
    assign pwIdx            = st.pwIdx;
    assign busy             = st.busy;
    assign done             = st.done;
    assign ok               = st.ok;
    assign needReset        = st.dead;
    assign reply            = st.reply;

    always_comb
    begin
        next_st         = st;
        next_st.txValid = 1'b0;
        next_st.txFe    = 1'b0;
        next_st.txOv    = 1'b0;
        next_st.done    = 1'b0;
        case (st.state)
            boot_cmd_pkg::H_READY:
            begin
                if (start)
                begin
                    next_st.op       = opSecurity;
                    next_st.setVal   = setValue;
                    next_st.addrSh   = {countAddr, compareAddr};
                    next_st.faultF   = injectFrameErr;
                    next_st.faultO   = injectOverrun;
                    next_st.lastStep = opSecurity ? boot_cmd_pkg::STEP_LAST_ADDR + {1'b0, pwLen}
                                                  : boot_cmd_pkg::STEP_FIRST_OP;
                    // once synced the device waits for a command, so syncs are skipped
                    next_st.step     = st.synced ? boot_cmd_pkg::STEP_CMD
                                                 : boot_cmd_pkg::STEP_SYNC1;
                    next_st.pwIdx    = 8'h00;
                    next_st.busy     = 1'b1;
                    next_st.ok       = 1'b0;
                    next_st.state    = boot_cmd_pkg::H_SEND;
                end
            end
            boot_cmd_pkg::H_SEND:
            begin
                next_st.txValid   = 1'b1;
                next_st.timer     = 8'h00;
                next_st.needReply = 1'b0;
                next_st.state     = boot_cmd_pkg::H_WAIT;
                if (st.step == boot_cmd_pkg::STEP_SYNC1)
                begin
                    next_st.txData    = boot_cmd_pkg::SYNC1_A;
                    next_st.expByte   = boot_cmd_pkg::SYNC1_A;
                    next_st.needReply = 1'b1;
                end
                else if (st.step == boot_cmd_pkg::STEP_SYNC2)
                begin
                    next_st.txData    = boot_cmd_pkg::SYNC2_A;
                    next_st.expByte   = boot_cmd_pkg::SYNC2_A;
                    next_st.needReply = 1'b1;
                end
                else if (st.step == boot_cmd_pkg::STEP_CMD)
                begin
                    next_st.txData    = st.op ? boot_cmd_pkg::CMD_SECURITY
                                              : boot_cmd_pkg::CMD_EMULATION;
                    next_st.expByte   = next_st.txData;
                    next_st.needReply = 1'b1;
                    next_st.txFe      = st.faultF;
                    next_st.txOv      = st.faultO;
                end
                else if (!st.op)
                begin
                    next_st.txData    = st.setVal;
                    next_st.expByte   = boot_cmd_pkg::ACK_EMULATION;
                    next_st.needReply = 1'b1;
                end
                else if (st.step < boot_cmd_pkg::STEP_PW)
                begin
                    next_st.txData = st.addrSh[47:40];
                    next_st.addrSh = {st.addrSh[39:0], 8'h00};
                end
                else
                begin
                    next_st.txData    = pwData;
                    next_st.pwIdx     = st.pwIdx + 8'h01;
                    next_st.expByte   = boot_cmd_pkg::ACK_SECURITY;
                    next_st.needReply = (st.step == st.lastStep);
                end
            end
            boot_cmd_pkg::H_WAIT:
            begin
                // a byte that needs a reply moves on when the reply comes; any other byte waits one full reply slot before the next goes out
                next_st.timer = st.timer + 8'h01;
                if (link.d2hValid)
                begin
                    next_st.reply = link.d2hData;
                end
                if (link.d2hValid && !(st.needReply && link.d2hData == st.expByte))
                begin
                    // error code, stray byte or wrong echo: the device is no longer usable
                    next_st.state = boot_cmd_pkg::H_DEAD;
                end
                else if ((st.needReply && link.d2hValid) ||
                         (!st.needReply && st.timer == boot_cmd_pkg::SLOT_CYC))
                begin
                    if (st.step == st.lastStep)
                    begin
                        next_st.synced = 1'b1;
                        next_st.ok     = 1'b1;
                        next_st.done   = 1'b1;
                        next_st.busy   = 1'b0;
                        next_st.state  = boot_cmd_pkg::H_READY;
                    end
                    else
                    begin
                        next_st.step  = st.step + 9'h001;
                        next_st.state = boot_cmd_pkg::H_SEND;
                    end
                end
                else if (st.timer == boot_cmd_pkg::SLOT_CYC)
                begin
                    next_st.state = boot_cmd_pkg::H_DEAD;
                end
            end
            boot_cmd_pkg::H_DEAD:
            begin
                if (!st.dead)
                begin
                    next_st.done = 1'b1;
                end
                next_st.dead = 1'b1;
                next_st.busy = 1'b0;
                if (link.d2hValid)
                begin
                    next_st.reply = link.d2hData;
                end
            end
            default:
            begin
                next_st.state = boot_cmd_pkg::H_DEAD;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st       <= '0;
            st.state <= boot_cmd_pkg::H_READY;
        end
        else
        begin
            st <= next_st;
        end
    end
endmodule
